/* File: hdl/pfc_defines.vh */
// Constants for the pause-frame control block: register map, field positions,
// reset values, memory word layout and engine states.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define PFC_OFF_CTRL 8'h00
`define PFC_OFF_STATUS 8'h04
`define PFC_OFF_GP_DA_LO 8'h08
`define PFC_OFF_GP_DA_HI 8'h0C
`define PFC_OFF_GP_SA_LO 8'h10
`define PFC_OFF_GP_SA_HI 8'h14
`define PFC_OFF_GP_TYPE_OP 8'h18
`define PFC_OFF_PP_DA_LO 8'h1C
`define PFC_OFF_PP_DA_HI 8'h20
`define PFC_OFF_PP_SA_LO 8'h24
`define PFC_OFF_PP_SA_HI 8'h28
`define PFC_OFF_PP_TYPE_OP 8'h2C
`define PFC_OFF_QUANTA_BASE 8'h40
`define PFC_OFF_REFRESH_BASE 8'h80
`define PFC_OFF_TABLE_LAST 8'h20

// ==========================================================================
// Field positions
// ==========================================================================
`define PFC_CTRL_CHECK_ACK 0
`define PFC_CTRL_TX_ENABLE 1
`define PFC_ST_REQ_LSB 0
`define PFC_ST_PEND_LSB 9
`define PFC_ST_BUSY 18
`define PFC_GLOBAL_IDX 8
`define PFC_NUM_IDX 9
`define PFC_REFRESH_WORD0 5'd9

// ==========================================================================
// Reset values
// ==========================================================================
`define PFC_CTRL_RESET 2'b10
`define PFC_ADDR_RESET 48'h0000_0000_0000
`define PFC_FIELD_RESET 16'h0000

// ==========================================================================
// Transmit engine states
// ==========================================================================
`define PFC_S_IDLE 3'd0
`define PFC_S_RDQ 3'd1
`define PFC_S_RDR 3'd2
`define PFC_S_LDR 3'd3
`define PFC_S_SEND 3'd4

// ==========================================================================
// Bus read latency in wait cycles
// ==========================================================================
`define PFC_RD_WAIT 2'd2

`endif

/* File: hdl/pfc_pause_ctrl.v */
// Pause-frame control: receive pause reporting and transmit pause generation.
// Assumes an AHB-Lite master, a receive parser and a MAC transmitter on hclk.
//
// What this block does
// - Standard pause frame sets valid bit 8
// - Valid bit marks its quanta as usable
// - Nine received quanta outputs, global in entry 8
// - Each request bit sends a pause frame
// - Nine transmit quanta, global in entry 8
// - Per-index refresh timer repeats pause frames
// - Global frames use global address/type/opcode fields
// - Priority frames use priority address/type/opcode fields
// - Resend repeats frames for all held request bits, resets refresh counters
// - Sent-status bit marks each sent frame
// - Receive request bit holds until processing done
// - Acknowledge awaited only when checking enabled
`timescale 1ns/10ps
`include "pfc_defines.vh"

module pfc_pause_ctrl #(
  parameter NQ = 9,
  parameter REFRESH_TICK = 16'h0001
) (
  // Clock, reset and enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Receive parser events
  input wire rx_frame_strobe,
  input wire [3:0] rx_frame_index,
  input wire [15:0] rx_frame_quanta,
  // Receive pause reporting to user logic
  output reg [NQ-1:0] rx_pause_valid,
  output reg [NQ*16-1:0] rx_pause_quanta,
  output reg [NQ-1:0] rx_pause_req,
  input wire [NQ-1:0] rx_pause_ack,
  // Transmit pause control from user logic
  input wire [NQ-1:0] tx_pause_req,
  input wire tx_resend_pause,
  output reg [NQ-1:0] tx_pause_sent,
  // Frame descriptor to the MAC transmitter
  output reg pf_valid,
  output reg [3:0] pf_index,
  output reg [47:0] pf_dest_addr,
  output reg [47:0] pf_src_addr,
  output reg [15:0] pf_ethertype,
  output reg [15:0] pf_opcode,
  output reg [15:0] pf_quanta,
  input wire pf_done
);

  // ========================================================================
  // Functions
  // ========================================================================
  // Map a byte offset to a memory word; bit 5 flags a hit
  function [5:0] mem_word;
    input [7:0] off;
    reg [7:0] rel;
    begin
      mem_word = 6'd0;
      if (off >= `PFC_OFF_REFRESH_BASE)
      begin
        rel = off - `PFC_OFF_REFRESH_BASE;
        if (rel <= `PFC_OFF_TABLE_LAST && rel[1:0] == 2'b00)
          mem_word = {1'b1, `PFC_REFRESH_WORD0 + {1'b0, rel[5:2]}};
      end
      else if (off >= `PFC_OFF_QUANTA_BASE)
      begin
        rel = off - `PFC_OFF_QUANTA_BASE;
        if (rel <= `PFC_OFF_TABLE_LAST && rel[1:0] == 2'b00)
          mem_word = {2'b10, rel[5:2]};
      end
    end
  endfunction

  // Highest pending index wins, so global pause goes first
  function [3:0] pick;
    input [NQ-1:0] vec;
    integer k;
    begin
      pick = 4'd0;
      for (k = 0; k < NQ; k = k + 1)
        if (vec[k])
          pick = k[3:0];
    end
  endfunction

  // ========================================================================
  // Bus slave and configuration registers
  // ========================================================================
  reg ap_write_q; // Write data phase pending
  reg [7:0] ap_addr_q; // Latched byte offset
  reg [1:0] rd_wait_q; // Read wait countdown
  reg [1:0] ctrl_q; // Check-ack and transmit enable
  reg [47:0] gp_da_q; // Global destination address
  reg [47:0] gp_sa_q; // Global source address
  reg [31:0] gp_typeop_q; // Global ethertype and opcode
  reg [47:0] pp_da_q; // Priority destination address
  reg [47:0] pp_sa_q; // Priority source address
  reg [31:0] pp_typeop_q; // Priority ethertype and opcode
  reg [NQ-1:0] pend_q; // Frames awaiting transmission
  reg [2:0] eng_q; // Transmit engine state
  reg [31:0] rd_mux; // Read data selection
  wire [5:0] wr_hit; // Memory hit for write phase
  wire [5:0] rd_hit; // Memory hit for read phase
  wire [15:0] mem_a_rdata; // Bus-side memory data
  wire [15:0] mem_b_rdata; // Engine-side memory data
  reg [4:0] eng_addr_q; // Engine memory address
  wire addr_phase; // Transfer taken this edge

  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_hit = mem_word(ap_addr_q);
  assign rd_hit = mem_word(ap_addr_q);

  // Read data mux, memory words come from port A
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (ap_addr_q)
      `PFC_OFF_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
      `PFC_OFF_STATUS: rd_mux = {13'h0000, (eng_q != `PFC_S_IDLE), pend_q, rx_pause_req};
      `PFC_OFF_GP_DA_LO: rd_mux = gp_da_q[31:0];
      `PFC_OFF_GP_DA_HI: rd_mux = {16'h0000, gp_da_q[47:32]};
      `PFC_OFF_GP_SA_LO: rd_mux = gp_sa_q[31:0];
      `PFC_OFF_GP_SA_HI: rd_mux = {16'h0000, gp_sa_q[47:32]};
      `PFC_OFF_GP_TYPE_OP: rd_mux = gp_typeop_q;
      `PFC_OFF_PP_DA_LO: rd_mux = pp_da_q[31:0];
      `PFC_OFF_PP_DA_HI: rd_mux = {16'h0000, pp_da_q[47:32]};
      `PFC_OFF_PP_SA_LO: rd_mux = pp_sa_q[31:0];
      `PFC_OFF_PP_SA_HI: rd_mux = {16'h0000, pp_sa_q[47:32]};
      `PFC_OFF_PP_TYPE_OP: rd_mux = pp_typeop_q;
      default:
      begin
        // Table words or unmapped, which reads zero
        if (rd_hit[5])
          rd_mux = {16'h0000, mem_a_rdata};
      end
    endcase
  end

  // Bus handshake and register writes; reads take two wait cycles
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
      rd_wait_q <= 2'd0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= `PFC_CTRL_RESET;
      gp_da_q <= `PFC_ADDR_RESET;
      gp_sa_q <= `PFC_ADDR_RESET;
      gp_typeop_q <= {`PFC_FIELD_RESET, `PFC_FIELD_RESET};
      pp_da_q <= `PFC_ADDR_RESET;
      pp_sa_q <= `PFC_ADDR_RESET;
      pp_typeop_q <= {`PFC_FIELD_RESET, `PFC_FIELD_RESET};
    end
    else if (ce)
    begin
      ap_write_q <= 1'b0;
      // Write data phase: store into the addressed register
      if (ap_write_q)
      begin
        case (ap_addr_q)
          `PFC_OFF_CTRL: ctrl_q <= hwdata[1:0];
          `PFC_OFF_GP_DA_LO: gp_da_q[31:0] <= hwdata;
          `PFC_OFF_GP_DA_HI: gp_da_q[47:32] <= hwdata[15:0];
          `PFC_OFF_GP_SA_LO: gp_sa_q[31:0] <= hwdata;
          `PFC_OFF_GP_SA_HI: gp_sa_q[47:32] <= hwdata[15:0];
          `PFC_OFF_GP_TYPE_OP: gp_typeop_q <= hwdata;
          `PFC_OFF_PP_DA_LO: pp_da_q[31:0] <= hwdata;
          `PFC_OFF_PP_DA_HI: pp_da_q[47:32] <= hwdata[15:0];
          `PFC_OFF_PP_SA_LO: pp_sa_q[31:0] <= hwdata;
          `PFC_OFF_PP_SA_HI: pp_sa_q[47:32] <= hwdata[15:0];
          `PFC_OFF_PP_TYPE_OP: pp_typeop_q <= hwdata;
          default:
          begin
            // Read-only, table or unmapped: no register here
          end
        endcase
      end
      // Read data phase countdown
      if (rd_wait_q != 2'd0)
      begin
        rd_wait_q <= rd_wait_q - 2'd1;
        if (rd_wait_q == 2'd1)
        begin
          hrdata <= rd_mux;
          hreadyout <= 1'b1;
        end
      end
      else if (addr_phase)
      begin
        // New address phase
        ap_addr_q <= haddr[7:0];
        ap_write_q <= hwrite;
        if (!hwrite)
        begin
          rd_wait_q <= `PFC_RD_WAIT;
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // Quanta and refresh table
  pfc_regmem #(
    .WIDTH(16),
    .DEPTH(2 * NQ),
    .AW(5)
  ) u_table (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .wr_en(ap_write_q & wr_hit[5]),
    .wr_addr(wr_hit[4:0]),
    .wr_data(hwdata[15:0]),
    .a_addr(rd_hit[4:0]),
    .a_rdata(mem_a_rdata),
    .b_addr(eng_addr_q),
    .b_rdata(mem_b_rdata)
  );

  // ========================================================================
  // Receive pause reporting
  // ========================================================================
  reg [NQ-1:0] rx_fresh_q; // Request raised last cycle

  // Valid pulse, quanta capture and held request
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_pause_valid <= {NQ{1'b0}};
      rx_pause_quanta <= {NQ*16{1'b0}};
      rx_pause_req <= {NQ{1'b0}};
      rx_fresh_q <= {NQ{1'b0}};
    end
    else if (ce)
    begin
      rx_pause_valid <= {NQ{1'b0}};
      rx_fresh_q <= {NQ{1'b0}};
      // Processing finishes on ack when checked, else a cycle later
      if (ctrl_q[`PFC_CTRL_CHECK_ACK])
        rx_pause_req <= rx_pause_req & ~rx_pause_ack;
      else
        rx_pause_req <= rx_pause_req & ~rx_fresh_q;
      if (rx_frame_strobe && rx_frame_index < NQ)
      begin
        // Index 8 is a standard pause frame; set wins over clear
        rx_pause_valid[rx_frame_index] <= 1'b1;
        rx_pause_quanta[rx_frame_index*16 +: 16] <= rx_frame_quanta;
        rx_pause_req[rx_frame_index] <= 1'b1;
        rx_fresh_q[rx_frame_index] <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Transmit refresh timers
  // ========================================================================
  reg [15:0] tick_q; // Refresh tick prescaler
  reg [NQ-1:0] req_d1_q; // Request delayed for edge detect
  reg [3:0] cur_q; // Index being sent
  reg [15:0] refresh_hold_q; // Refresh value for current index
  wire tick; // One refresh step
  wire frame_end; // Current frame completed
  wire [NQ-1:0] expire; // Refresh timer ran out

  assign tick = (tick_q == REFRESH_TICK - 16'h0001);
  assign frame_end = (eng_q == `PFC_S_SEND) & pf_done;

  // Prescaler for refresh counting
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_q <= 16'h0000;
    else if (ce)
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NQ; gi = gi + 1)
    begin : g_refresh
      reg [15:0] cnt_q; // Time left before repeat
      reg armed_q; // Counter running
      assign expire[gi] = armed_q & tick & (cnt_q == 16'h0001);

      // Per-index retransmit counter
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cnt_q <= 16'h0000;
          armed_q <= 1'b0;
        end
        else if (ce)
        begin
          if (tx_resend_pause || !tx_pause_req[gi])
          begin
            // Resend or dropped request stops the counter
            armed_q <= 1'b0;
            cnt_q <= 16'h0000;
          end
          else if (frame_end && cur_q == gi)
          begin
            // Reload from the refresh table; zero means no repeat
            cnt_q <= refresh_hold_q;
            armed_q <= (refresh_hold_q != 16'h0000);
          end
          else if (expire[gi])
            armed_q <= 1'b0;
          else if (armed_q && tick)
            cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  endgenerate

  // ========================================================================
  // Transmit engine
  // ========================================================================
  wire [NQ-1:0] pend_set; // New reasons to send
  assign pend_set = (tx_pause_req & ~req_d1_q) | expire
    | (tx_pause_req & {NQ{tx_resend_pause}});

  // Pending set, frame build and descriptor hand-off
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_d1_q <= {NQ{1'b0}};
      pend_q <= {NQ{1'b0}};
      eng_q <= `PFC_S_IDLE;
      eng_addr_q <= 5'd0;
      cur_q <= 4'd0;
      refresh_hold_q <= 16'h0000;
      tx_pause_sent <= {NQ{1'b0}};
      pf_valid <= 1'b0;
      pf_index <= 4'd0;
      pf_dest_addr <= `PFC_ADDR_RESET;
      pf_src_addr <= `PFC_ADDR_RESET;
      pf_ethertype <= `PFC_FIELD_RESET;
      pf_opcode <= `PFC_FIELD_RESET;
      pf_quanta <= `PFC_FIELD_RESET;
    end
    else if (ce)
    begin
      req_d1_q <= tx_pause_req;
      tx_pause_sent <= {NQ{1'b0}};
      case (eng_q)
        `PFC_S_IDLE:
        begin
          // Take one pending index; a new set in the same cycle wins
          if (ctrl_q[`PFC_CTRL_TX_ENABLE] && pend_q != {NQ{1'b0}})
          begin
            cur_q <= pick(pend_q);
            eng_addr_q <= {1'b0, pick(pend_q)};
            pend_q <= (pend_q & ~({{NQ-1{1'b0}}, 1'b1} << pick(pend_q))) | pend_set;
            eng_q <= `PFC_S_RDQ;
          end
          else
            pend_q <= pend_q | pend_set;
        end
        `PFC_S_RDQ:
        begin
          // Quanta word in flight, ask for the refresh word
          pend_q <= pend_q | pend_set;
          eng_addr_q <= `PFC_REFRESH_WORD0 + {1'b0, cur_q};
          eng_q <= `PFC_S_RDR;
        end
        `PFC_S_RDR:
        begin
          pend_q <= pend_q | pend_set;
          pf_quanta <= mem_b_rdata;
          eng_q <= `PFC_S_LDR;
        end
        `PFC_S_LDR:
        begin
          // Fill the frame fields by kind and offer it
          pend_q <= pend_q | pend_set;
          refresh_hold_q <= mem_b_rdata;
          pf_index <= cur_q;
          pf_valid <= 1'b1;
          if (cur_q == `PFC_GLOBAL_IDX)
          begin
            pf_dest_addr <= gp_da_q;
            pf_src_addr <= gp_sa_q;
            pf_ethertype <= gp_typeop_q[31:16];
            pf_opcode <= gp_typeop_q[15:0];
          end
          else
          begin
            pf_dest_addr <= pp_da_q;
            pf_src_addr <= pp_sa_q;
            pf_ethertype <= pp_typeop_q[31:16];
            pf_opcode <= pp_typeop_q[15:0];
          end
          eng_q <= `PFC_S_SEND;
        end
        `PFC_S_SEND:
        begin
          // Frame in flight; resend waits here until it completes
          pend_q <= pend_q | pend_set;
          if (pf_done)
          begin
            pf_valid <= 1'b0;
            tx_pause_sent[cur_q] <= 1'b1;
            eng_q <= `PFC_S_IDLE;
          end
        end
        default:
        begin
          pend_q <= pend_q | pend_set;
          eng_q <= `PFC_S_IDLE;
        end
      endcase
    end
  end

endmodule // pfc_pause_ctrl

/* File: hdl/pfc_regmem.v */
// Small word memory holding the transmit quanta and refresh timer values.
// Assumes one clock, one write port and two registered read ports.
`timescale 1ns/10ps

module pfc_regmem #(
  parameter WIDTH = 16,
  parameter DEPTH = 18,
  parameter AW = 5
) (
  // Clock, reset and enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port A (bus side)
  input wire [AW-1:0] a_addr,
  output reg [WIDTH-1:0] a_rdata,
  // Read port B (engine side)
  input wire [AW-1:0] b_addr,
  output reg [WIDTH-1:0] b_rdata
);

  // Storage array
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Array write; no reset, software loads it before use
  always @(posedge hclk)
  begin
    if (ce && wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered reads on both ports
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_rdata <= {WIDTH{1'b0}};
      b_rdata <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule // pfc_regmem

/* File: sim/pfc_chk_sva.sv */
// Checker for the pause-frame control block, watching its ports only.
// Assumes binding into pfc_pause_ctrl; one clock, reset active low.
`timescale 1ns/10ps
module pfc_chk #(
  parameter NQ = 9
) (
  // Clock, reset, bus
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // Receive side
  input wire rx_frame_strobe,
  input wire [3:0] rx_frame_index,
  input wire [15:0] rx_frame_quanta,
  input wire [NQ-1:0] rx_pause_valid,
  input wire [NQ*16-1:0] rx_pause_quanta,
  input wire [NQ-1:0] rx_pause_req,
  input wire [NQ-1:0] rx_pause_ack,
  // Transmit side
  input wire [NQ-1:0] tx_pause_req,
  input wire [NQ-1:0] tx_pause_sent,
  input wire pf_valid,
  input wire [3:0] pf_index,
  input wire [47:0] pf_dest_addr,
  input wire [15:0] pf_quanta,
  input wire pf_done
);
  // ==========================================================
  // Properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_rx_global: assert property (
    ce && rx_frame_strobe && rx_frame_index == 4'h8 |=> rx_pause_valid[8]
    && rx_pause_quanta[143:128] == $past(rx_frame_quanta)) else $error("global rx wrong");
  a_rx_cause: assert property (
    rx_pause_valid != 9'h000 |-> $past(rx_frame_strobe) && $past(rx_frame_index) < 4'h9)
    else $error("rx valid without frame");
  a_rx_req_set: assert property (
    rx_pause_valid[8] |-> rx_pause_req[8]) else $error("rx req not raised");
  a_rx_req_free: assert property (
    $fell(rx_pause_req[8]) |-> $past(rx_pause_ack[8]) || $past(rx_pause_valid[8]))
    else $error("rx req dropped early");
  a_tx_req_frame: assert property (
    $rose(tx_pause_req[8]) |-> ##[1:400] pf_valid && pf_index == 4'h8)
    else $error("no global frame");
  a_pf_hold: assert property (
    pf_valid && !pf_done |=> pf_valid && $stable(pf_quanta) && $stable(pf_dest_addr)
    && $stable(pf_index)) else $error("frame fields moved");
  a_sent_index: assert property (
    pf_valid && pf_done |=> !pf_valid && tx_pause_sent == (9'h001 << $past(pf_index)))
    else $error("sent flag wrong");
  a_sent_pulse: assert property (
    tx_pause_sent != 9'h000 |-> $past(pf_done) ##1 tx_pause_sent == 9'h000)
    else $error("sent flag not a pulse");
  a_rd_wait: assert property (
    ce && hsel && htrans[1] && !hwrite && hready |=> !hreadyout [*2] ##1 hreadyout)
    else $error("read wait wrong");
  a_bus_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
endmodule // pfc_chk
bind pfc_pause_ctrl pfc_chk #(.NQ(NQ)) chk_u (.*);

/* File: sim/pfc_far_model.sv */
// Far side: MAC transmitter completion and user pause acknowledge.
// Assumes the block's clock and reset.
`timescale 1ns/10ps
module pfc_far_model (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Frame hand-off
  input wire pf_valid,
  input wire [3:0] done_dly,
  output reg pf_done,
  // Pause acknowledge
  input wire ack_en,
  input wire [8:0] rx_pause_req,
  output reg [8:0] rx_pause_ack
);
  reg [3:0] cnt_q; // Cycles the frame was offered
  reg [8:0] req_q; // Request one cycle ago
  // ==========================================================
  // Completion after a chosen delay, only while offered
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 4'h0;
      pf_done <= 1'b0;
    end
    else if (pf_valid && !pf_done)
    begin
      cnt_q <= cnt_q + 4'h1;
      pf_done <= (cnt_q == done_dly);
    end
    else
    begin
      cnt_q <= 4'h0;
      pf_done <= 1'b0;
    end
  end
  // Acknowledge two cycles after a request, when enabled
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_q <= 9'h000;
      rx_pause_ack <= 9'h000;
    end
    else
    begin
      req_q <= rx_pause_req;
      rx_pause_ack <= ack_en ? req_q : 9'h000;
    end
  end
endmodule // pfc_far_model

/* File: sim/tb.sv */
// Bench: bus, receive reports and transmitted pause frames.
// Assumes the design, far model and checker compile first.
`timescale 1ns/10ps
`include "pfc_defines.vh"
module tb;
  // ==========================================================
  // Signals
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg [31:0] haddr = 32'h0000_0000;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0000_0000;
  reg rx_frame_strobe = 1'b0;
  reg [3:0] rx_frame_index = 4'h0;
  reg [15:0] rx_frame_quanta = 16'h0000;
  reg [8:0] tx_pause_req = 9'h000;
  reg tx_resend_pause = 1'b0;
  reg ack_en = 1'b0;
  reg [3:0] done_dly = 4'h0;
  reg rdp_q = 1'b0; // Read data phase open
  reg [7:0] ba; // Register offset
  wire [31:0] hrdata;
  wire hreadyout;
  wire [8:0] rx_pause_valid;
  wire [143:0] rx_pause_quanta;
  wire [8:0] rx_pause_req;
  wire [8:0] rx_pause_ack;
  wire [8:0] tx_pause_sent;
  wire pf_valid;
  wire [3:0] pf_index;
  wire [47:0] pf_dest_addr;
  wire [47:0] pf_src_addr;
  wire [15:0] pf_ethertype;
  wire [15:0] pf_opcode;
  wire [15:0] pf_quanta;
  wire pf_done;
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer seed = 32'ha2f3a05d;
  integer i;
  integer cyc = 0;
  integer t0;
  logic [31:0] rd_q[$];
  logic [28:0] rx_q[$];
  logic [147:0] fr_q[$];
  logic [15:0] tq[0:8]; // Quanta table
  logic [127:0] cfg[0:1]; // Opcode, type, DA, SA; 1 is global
  always #25 hclk = ~hclk;
  pfc_pause_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .rx_frame_strobe(rx_frame_strobe), .rx_frame_index(rx_frame_index),
    .rx_frame_quanta(rx_frame_quanta), .rx_pause_valid(rx_pause_valid),
    .rx_pause_quanta(rx_pause_quanta), .rx_pause_req(rx_pause_req),
    .rx_pause_ack(rx_pause_ack), .tx_pause_req(tx_pause_req),
    .tx_resend_pause(tx_resend_pause), .tx_pause_sent(tx_pause_sent),
    .pf_valid(pf_valid), .pf_index(pf_index), .pf_dest_addr(pf_dest_addr),
    .pf_src_addr(pf_src_addr), .pf_ethertype(pf_ethertype), .pf_opcode(pf_opcode),
    .pf_quanta(pf_quanta), .pf_done(pf_done));
  pfc_far_model far_u (.hclk(hclk), .hresetn(hresetn), .pf_valid(pf_valid),
    .done_dly(done_dly), .pf_done(pf_done), .ack_en(ack_en),
    .rx_pause_req(rx_pause_req), .rx_pause_ack(rx_pause_ack));
  // ==========================================================
  // Tasks
  task chk(input string nm, input [147:0] e, input [147:0] s);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task close_out;
    begin
      $display("Counts: %0d compared, %0d mismatched", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Wait for a sent flag, or bus ready when idx is 15
  task wait_on(input [3:0] idx);
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while ((idx == 4'hF ? hreadyout : tx_pause_sent[idx]) !== 1'b1 && n < 500)
      begin
        n = n + 1;
        @(posedge hclk);
      end
      if (n == 500)
      begin
        chk("wait", 0, 1);
        close_out;
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d, input [31:0] e);
    begin
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      if (!w)
        rd_q.push_back(e);
      wait_on(4'hF);
      htrans <= 2'b00;
      hwdata <= d;
      wait_on(4'hF);
    end
  endtask
  task rx_send(input [3:0] idx, input [15:0] q);
    begin
      rx_frame_strobe <= 1'b1;
      rx_frame_index <= idx;
      rx_frame_quanta <= q;
      if (idx < 4'h9)
        rx_q.push_back({idx, 9'h001 << idx, q});
      @(posedge hclk);
    end
  endtask
  function [147:0] fexp(input [3:0] idx);
    fexp = {idx, tq[idx], cfg[idx == 4'h8]};
  endfunction
  // ==========================================================
  // Monitors: each result takes the oldest note
  always @(posedge hclk)
  begin : mon
    logic [28:0] e;
    cyc <= cyc + 1;
    if (hreadyout)
      rdp_q <= htrans[1] && !hwrite;
    if (rdp_q && hreadyout)
      chk("read", rd_q.size() ? rd_q.pop_front() : 'x, hrdata);
    if (pf_valid && pf_done)
      chk("frame", fr_q.size() ? fr_q.pop_front() : 'x, {pf_index, pf_quanta, pf_opcode,
        pf_ethertype, pf_dest_addr, pf_src_addr});
    if (rx_pause_valid !== 9'h000)
    begin
      e = rx_q.size() ? rx_q.pop_front() : 'x;
      chk("rx", e, {e[28:25], rx_pause_valid, rx_pause_quanta[e[28:25]*16 +: 16]});
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `PFC_OFF_CTRL, 0, 32'h0000_0002);
    bus(1'b0, 8'hFC, 0, 0);
    for (i = 0; i < 2; i = i + 1)
    begin
      cfg[i] = {$random(seed), $random(seed), $random(seed), $random(seed)};
      ba = i ? `PFC_OFF_GP_DA_LO : `PFC_OFF_PP_DA_LO;
      bus(1'b1, ba, cfg[i][79:48], 0);
      bus(1'b1, ba + 8'h04, {16'h0000, cfg[i][95:80]}, 0);
      bus(1'b1, ba + 8'h08, cfg[i][31:0], 0);
      bus(1'b1, ba + 8'h0C, {16'h0000, cfg[i][47:32]}, 0);
      bus(1'b1, ba + 8'h10, {cfg[i][111:96], cfg[i][127:112]}, 0);
      bus(1'b0, ba + 8'h10, 0, {cfg[i][111:96], cfg[i][127:112]});
    end
    for (i = 0; i < 9; i = i + 1)
    begin
      tq[i] = 16'($random(seed));
      ba = {i[5:0], 2'b00};
      bus(1'b1, `PFC_OFF_QUANTA_BASE + ba, {16'h0000, tq[i]}, 0);
      bus(1'b1, `PFC_OFF_REFRESH_BASE + ba, 0, 0);
    end
    bus(1'b0, `PFC_OFF_QUANTA_BASE + `PFC_OFF_TABLE_LAST, 0, {16'h0000, tq[8]});
    $display("Test registers done");
    for (i = 0; i < 10; i = i + 1)
      rx_send(i[3:0], 16'($random(seed)));
    rx_frame_strobe <= 1'b0;
    bus(1'b1, `PFC_OFF_CTRL, 32'h0000_0003, 0);
    ack_en <= 1'b1;
    rx_send(4'h8, 16'hFFFF);
    rx_frame_strobe <= 1'b0;
    for (i = 0; i < 3 || (rx_pause_req[8] !== 1'b0 && i < 40); i = i + 1)
      @(posedge hclk);
    chk("rx req hold", 1, i > 3 && i < 40);
    ack_en <= 1'b0;
    bus(1'b1, `PFC_OFF_CTRL, 32'h0000_0002, 0);
    $display("Test receive done");
    for (i = 0; i < 9; i = i + 1)
    begin
      done_dly <= 4'($random(seed));
      fr_q.push_back(fexp(i[3:0]));
      tx_pause_req <= 9'h001 << i;
      wait_on(i[3:0]);
    end
    tx_pause_req <= 9'h000;
    @(posedge hclk);
    tx_pause_req <= 9'h108;
    for (i = 0; i < 2; i = i + 1)
    begin
      fr_q.push_back(fexp(4'h8));
      fr_q.push_back(fexp(4'h3));
      wait_on(4'h3);
      tx_resend_pause <= !i;
      @(posedge hclk) tx_resend_pause <= 1'b0;
    end
    tx_pause_req <= 9'h000;
    bus(1'b1, `PFC_OFF_REFRESH_BASE + 8'h14, 32'h0000_0014, 0);
    tx_pause_req <= 9'h020;
    fr_q.push_back(fexp(4'h5));
    fr_q.push_back(fexp(4'h5));
    wait_on(4'h5);
    t0 = cyc;
    wait_on(4'h5);
    tx_pause_req <= 9'h000;
    chk("refresh gap", 1, cyc - t0 >= 20 && cyc - t0 < 60);
    repeat (60) @(posedge hclk);
    $display("Test transmit done");
    close_out;
  end
endmodule // tb
